// >>> core/crtac_pkg.sv
// Purpose: Shared constants for the CRT attribute, cursor and refresh block
// Assumes: System clock of 25 MHz; video dot rate is synthesised from it
// Notes:   All geometry and offsets, and the APB register reset values, live here
package crtac_pkg;

  // Clock plan
  localparam longint   SYS_HZ     = 64'd25000000;
  localparam longint   VIDEO_HZ   = 64'd17074800;
  localparam longint   CPU_HZ     = 64'd950000;  // Nominal, falls out of CHAR_DIV*2
  localparam int       ACC_W      = 16;
  localparam logic [ACC_W-1:0] DOT_INC = ACC_W'((VIDEO_HZ << ACC_W) / SYS_HZ);
  localparam logic [3:0] CHAR_DIV  = 4'h9;

  // Screen geometry in character cells
  localparam logic [6:0]  H_TOTAL    = 7'h64;   // 100 cells incl. retrace
  localparam logic [6:0]  H_ACTIVE   = 7'h50;   // 80 displayed cells
  localparam logic [6:0]  HS_START   = 7'h54;
  localparam logic [6:0]  HS_END     = 7'h5b;
  localparam logic [3:0]  SCAN_LAST  = 4'hb;    // 12 scans per text row
  localparam logic [4:0]  ROW_ACTIVE = 5'h18;   // 24 text rows
  localparam logic [4:0]  ROW_LAST   = 5'h19;
  localparam logic [4:0]  VS_ROW     = 5'h19;
  localparam logic [10:0] START_ADDR = 11'h080;
  localparam logic [10:0] LINE_STEP  = 11'h050;

  // Attribute bit positions
  localparam int ATTR_REV   = 0;
  localparam int ATTR_BLANK = 1;
  localparam int ATTR_ULINE = 2;

  // APB register map
  localparam logic [11:0] REG_CUR_LO = 12'h000;
  localparam logic [11:0] REG_CUR_HI = 12'h004;
  localparam logic [11:0] REG_CTRL   = 12'h008;
  localparam logic [11:0] REG_STAT   = 12'h00c;
  localparam int          CTRL_EMB   = 0;
  localparam int          CTRL_WIDE  = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h1;
  localparam logic [10:0] CUR_RST    = 11'h000;
  localparam int          STAT_VBLK  = 8;

endpackage

// >>> core/crtac_clkgen.sv
// Purpose: Dot and character rate enables from the system clock
// Assumes: pclk is the only clock; rates are one-cycle enables
// Notes:   Phase accumulator gives the video rate on average, with jitter
`timescale 1ns/1ps
module crtac_clkgen
  import crtac_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      dot_en,
  output logic      char_en
);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0]   acc_sum;
  logic [3:0]       div_r;

  assign acc_sum = {1'b0, acc_r} + {1'b0, DOT_INC};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= '0;
      dot_en <= 1'b0;
    end else begin
      acc_r  <= acc_sum[ACC_W-1:0];
      dot_en <= acc_sum[ACC_W];
    end
  end

  // Character enable coincides with every ninth dot enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r   <= 4'h0;
      char_en <= 1'b0;
    end else begin
      char_en <= 1'b0;
      if (acc_sum[ACC_W]) begin
        if (div_r == CHAR_DIV - 4'h1) begin // R13
          div_r   <= 4'h0;
          char_en <= 1'b1;
        end else begin
          div_r <= div_r + 4'h1;
        end
      end
    end
  end

endmodule

// >>> core/crtac_regs.sv
// Purpose: APB register slave for cursor, mode control and status
// Assumes: APB3 signalling, one wait state on every access
// Notes:   Unmapped or misaligned addresses answer with pslverr, read zero
`timescale 1ns/1ps
module crtac_regs
  import crtac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [10:0] cursor,
  output logic             emb_en,
  output logic             wide_en,
  input  wire logic [6:0]  stat_attr,
  input  wire logic        stat_vblank
);

  logic        mapped;
  logic        wr_go;
  logic [31:0] rd_mux;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr)
      REG_CUR_LO: rd_mux[7:0] = cursor[7:0];
      REG_CUR_HI: rd_mux[2:0] = cursor[10:8];
      REG_CTRL: begin
        rd_mux[CTRL_EMB]  = emb_en;
        rd_mux[CTRL_WIDE] = wide_en;
      end
      REG_STAT: begin
        rd_mux[6:0]       = stat_attr;
        rd_mux[STAT_VBLK] = stat_vblank;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Write lands on the edge that samples pready high
  assign wr_go = psel & penable & pready & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor  <= CUR_RST;
      emb_en  <= CTRL_RST[CTRL_EMB];
      wide_en <= CTRL_RST[CTRL_WIDE];
    end else if (wr_go) begin
      if (paddr == REG_CUR_LO) cursor[7:0] <= pwdata[7:0]; // R6
      if (paddr == REG_CUR_HI) cursor[10:8] <= pwdata[2:0]; // R6
      if (paddr == REG_CTRL) begin
        emb_en  <= pwdata[CTRL_EMB];
        wide_en <= pwdata[CTRL_WIDE];
      end
    end
  end

endmodule

// >>> core/crtac_top.sv
// Purpose: Character CRT display timing with field attributes and cursor
// Assumes: Refresh memory is 16 bits wide (even byte low), read in one cycle
// Notes:   Display runs two cells behind the fetch; dot ROM is external
//
// What this block does
// (R1) In embedded mode with wide mode off, a fetched code with top bit set is an attribute code.
// (R2) An attribute code's low seven bits are captured in the attribute latch.
// (R3) The latched attribute governs following characters until replaced.
// (R4) The attribute latch clears in hardware at every displayed line end.
// (R5) Wide mode: each character carries its own independent attribute bits.
// (R6) Cursor is eleven bits: low byte and upper three bits written separately.
// (R7) Cursor is a linear memory address, one screen cell per value.
// (R8) Refresh uses phase one only, processor uses phase two only.
// (R9) Both phases run continuously, also while the processor waits.
// (R10) Each refresh fetch is held in a single latch, no FIFO.
// (R11) Processor clock is derived from the character rate, near 950 kHz.
// (R12) Refresh address is compared with cursor; coincidence is flagged.
// (R13) Character rate is the video clock divided by nine.
// (R14) The cursor cell is shown as an inverted block.
`timescale 1ns/1ps
module crtac_top
  import crtac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Refresh memory
  output logic      [9:0]  mem_addr,
  output logic      [1:0]  mem_be,
  output logic             mem_we,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic [15:0] mem_rattr,
  // Processor access port
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [10:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_ack,
  output logic             phi1,
  output logic             phi2,
  // Video
  output logic      [7:0]  glyph_code,
  output logic      [3:0]  glyph_row,
  input  wire logic [7:0]  dot_pattern,
  output logic             video,
  output logic             hsync,
  output logic             vsync,
  output logic             blank,
  output logic      [6:0]  attr_out,
  output logic             cursor_hit
);

  function automatic logic [7:0] pick_byte(input logic odd, input logic [15:0] w);
    pick_byte = odd ? w[15:8] : w[7:0];
  endfunction

  logic        dot_en;
  logic        char_en;
  logic [10:0] cursor;
  logic        emb_en;
  logic        wide_en;

  logic [6:0]  col_r;
  logic [3:0]  scan_r;
  logic [4:0]  row_r;
  logic [10:0] line_start_r;
  logic [10:0] line_start_nxt;
  logic        vactive;
  logic        col_last;

  logic [15:0] fetch_r;
  logic [15:0] fetch_attr_r;
  logic        cpu_pend_r;
  logic        cpu_lane_r;
  logic [10:0] ref_next;

  logic [6:0]  attr_latch_r;
  logic        a_valid;
  logic [7:0]  a_code;
  logic [7:0]  a_wattr;
  logic        a_fac;
  logic [10:0] a_addr;
  logic        on_a_r;
  logic        hide_a_r;
  logic        hit_a_r;
  logic [6:0]  attr_a_r;

  logic [8:0]  shift_r;
  logic        on_b_r;
  logic        hit_b_r;
  logic [6:0]  attr_b_r;
  logic        pix;

  ////////////////////////////////////////////////////////////////////////////
  crtac_clkgen u_clkgen (
    .pclk    (pclk),
    .presetn (presetn),
    .dot_en  (dot_en),
    .char_en (char_en)
  );

  crtac_regs u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .paddr       (paddr),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .cursor      (cursor),
    .emb_en      (emb_en),
    .wide_en     (wide_en),
    .stat_attr   (attr_latch_r),
    .stat_vblank (~vactive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Raster counters
  assign vactive  = row_r < ROW_ACTIVE;
  assign col_last = col_r == H_TOTAL - 7'h01;

  always_comb begin
    line_start_nxt = line_start_r;
    if (scan_r == SCAN_LAST) begin
      if (row_r == ROW_LAST) begin
        line_start_nxt = START_ADDR;
      end else begin
        line_start_nxt = line_start_r + LINE_STEP;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_r        <= 7'h00;
      scan_r       <= 4'h0;
      row_r        <= 5'h00;
      line_start_r <= START_ADDR;
    end else if (char_en) begin
      col_r <= col_last ? 7'h00 : col_r + 7'h01;
      if (col_last) begin
        // Same line start reused for all twelve scans of a text row
        line_start_r <= line_start_nxt;
        scan_r       <= (scan_r == SCAN_LAST) ? 4'h0 : scan_r + 4'h1;
        if (scan_r == SCAN_LAST) begin
          row_r <= (row_r == ROW_LAST) ? 5'h00 : row_r + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-phase memory sharing: even cell periods are phase one, odd ones
  // phase two, so the processor cycle is twice the character period.
  assign ref_next = col_last ? line_start_nxt : line_start_r + {4'h0, col_r} + 11'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phi1       <= 1'b1;
      phi2       <= 1'b0;
      mem_addr   <= START_ADDR[10:1];
      mem_be     <= 2'h3;
      mem_we     <= 1'b0;
      mem_wdata  <= 16'h0000;
      cpu_pend_r <= 1'b0;
      cpu_lane_r <= 1'b0;
      cpu_rdata  <= 8'h00;
      cpu_ack    <= 1'b0;
      fetch_r      <= 16'h0000;
      fetch_attr_r <= 16'h0000;
    end else begin
      cpu_ack <= 1'b0;
      if (char_en) begin
        // Phases never pause; a stalled processor cannot stop refresh
        phi1 <= col_r[0]; // R9 R11
        phi2 <= ~col_r[0]; // R9 R11
        if (col_r[0]) begin
          // End of phase two: finish processor access, start refresh
          mem_addr <= ref_next[10:1]; // R8
          mem_be   <= 2'h3;
          mem_we   <= 1'b0;
          if (cpu_pend_r) begin
            cpu_rdata  <= pick_byte(cpu_lane_r, mem_rdata);
            cpu_ack    <= 1'b1;
            cpu_pend_r <= 1'b0;
          end
        end else begin
          // End of phase one: hold the pair, then hand memory to processor
          fetch_r      <= mem_rdata; // R10
          fetch_attr_r <= mem_rattr; // R10 R5
          if (cpu_req) begin
            mem_addr   <= cpu_addr[10:1]; // R8
            mem_be     <= cpu_addr[0] ? 2'h2 : 2'h1;
            mem_we     <= cpu_we;
            mem_wdata  <= {cpu_wdata, cpu_wdata};
            cpu_pend_r <= 1'b1;
            cpu_lane_r <= cpu_addr[0];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage A: pick the cell from the latch, decode attributes, compare cursor
  assign a_valid = vactive && (col_r != 7'h00) && (col_r <= H_ACTIVE);
  assign a_code  = pick_byte(~col_r[0], fetch_r);
  assign a_wattr = pick_byte(~col_r[0], fetch_attr_r);
  assign a_fac   = emb_en && !wide_en && a_code[7]; // R1
  assign a_addr  = line_start_r + {4'h0, col_r} - 11'h001; // R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attr_latch_r <= 7'h00;
    end else if (char_en) begin
      if (col_r == H_ACTIVE) begin
        attr_latch_r <= 7'h00; // R4
      end else if (a_valid && a_fac) begin
        attr_latch_r <= a_code[6:0]; // R2
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_a_r     <= 1'b0;
      hide_a_r   <= 1'b1;
      hit_a_r    <= 1'b0;
      attr_a_r   <= 7'h00;
      glyph_code <= 8'h00;
      glyph_row  <= 4'h0;
    end else if (char_en) begin
      on_a_r    <= a_valid;
      // Attribute codes take a cell but show as blank
      hide_a_r  <= !a_valid || a_fac;
      hit_a_r   <= a_valid && (a_addr == cursor); // R12
      // Wide mode uses the cell's own bits and ignores the latch
      attr_a_r  <= wide_en ? a_wattr[6:0] : attr_latch_r; // R3 R5
      glyph_code <= (emb_en && !wide_en) ? {1'b0, a_code[6:0]} : a_code;
      glyph_row <= scan_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage B: dot ROM answer is loaded one cell after the code went out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r  <= 9'h000;
      on_b_r   <= 1'b0;
      hit_b_r  <= 1'b0;
      attr_b_r <= 7'h00;
    end else if (char_en) begin
      // First dot repeats pattern bit 7, so bit 7 shows twice and bit 0 is the ninth dot
      shift_r  <= hide_a_r ? 9'h000 : {dot_pattern[7], dot_pattern};
      on_b_r   <= on_a_r;
      hit_b_r  <= hit_a_r;
      attr_b_r <= attr_a_r;
    end else if (dot_en) begin
      shift_r <= {shift_r[7:0], 1'b0};
    end
  end

  assign pix = (shift_r[8] & ~attr_b_r[ATTR_BLANK])
             | (attr_b_r[ATTR_ULINE] && glyph_row == SCAN_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video      <= 1'b0;
      blank      <= 1'b1;
      hsync      <= 1'b0;
      vsync      <= 1'b0;
      attr_out   <= 7'h00;
      cursor_hit <= 1'b0;
    end else begin
      video      <= on_b_r & (pix ^ attr_b_r[ATTR_REV] ^ hit_b_r); // R14
      blank      <= ~on_b_r;
      hsync      <= (col_r >= HS_START) && (col_r <= HS_END);
      vsync      <= row_r == VS_ROW;
      attr_out   <= attr_b_r;
      cursor_hit <= hit_b_r; // R12
    end
  end

endmodule

// >>> verif/crtac_checker.sv
// Purpose: Assertions on phase sharing and bus timing of crtac_top
// Assumes: Bound to crtac_top; one clock, reset active low
// Notes:   Phase length bounds are loose to absorb dot-rate jitter
`timescale 1ns/1ps
module crtac_checker
  import crtac_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       phi1,
  input wire logic       phi2,
  input wire logic       mem_we,
  input wire logic [1:0] mem_be,
  input wire logic       cpu_ack
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_ph2_start;
    $rose(phi2);
  endsequence
  sequence s_ph2_end;
    $fell(phi2);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_PHASE_EXCL: assert property (phi1 != phi2)
    else $error("phases not complementary");
  AST_WE_IN_PH2: assert property (mem_we |-> phi2 && (mem_be == 2'h1 || mem_be == 2'h2))
    else $error("write outside phase two or on both lanes");
  AST_REFRESH_LANES: assert property (phi1 |-> mem_be == 2'h3 && !mem_we)
    else $error("refresh fetch not a full word read");
  AST_WE_WHOLE: assert property ($rose(mem_we) |-> s_ph2_start)
    else $error("write strobe rose inside phase two");
  AST_WE_DROP: assert property (s_ph2_end |-> !mem_we)
    else $error("write strobe outlived phase two");
  AST_PH2_LEN: assert property (s_ph2_start |-> phi2[*8] ##[1:22] s_ph2_end)
    else $error("phase two length out of range");
  AST_ACK_AT_END: assert property (cpu_ack |-> $rose(phi1) ##1 !cpu_ack)
    else $error("processor ack not a pulse at end of phase two");
  AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
endmodule

// >>> verif/crtac_mem_model.sv
// Purpose: Refresh memory with a parallel page of per-character attributes
// Assumes: Byte array, even byte on the low lane
// Notes:   Reads are combinational, so data is settled long before phase end
`timescale 1ns/1ps
module crtac_mem_model
  import crtac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [9:0]  mem_addr,
  input  wire logic [1:0]  mem_be,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic      [15:0] mem_rattr
);
  logic [7:0] ram  [0:2047];
  logic [7:0] attr [0:2047];

  assign mem_rdata = {ram[{mem_addr, 1'b1}], ram[{mem_addr, 1'b0}]};
  assign mem_rattr = {attr[{mem_addr, 1'b1}], attr[{mem_addr, 1'b0}]};

  // Processor bytes land one lane at a time
  always @(posedge pclk) begin
    if (mem_we) begin
      if (mem_be[0]) ram[{mem_addr, 1'b0}] <= mem_wdata[7:0];
      if (mem_be[1]) ram[{mem_addr, 1'b1}] <= mem_wdata[15:8];
    end
  end
endmodule

// >>> verif/tb_crt_attribute_cursor_refresh.sv
// Purpose: Self-checking bench for the CRT attribute, cursor and refresh block
// Assumes: Text row 0 is on display during the first scan lines after reset
// Notes:   Windows are in pclk cycles and allow for dot-rate jitter
`timescale 1ns/1ps
module tb_crt_attribute_cursor_refresh
  import crtac_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, mem_we, cpu_ack, phi1, phi2, err;
  logic        video, hsync, vsync, blank, cursor_hit;
  logic [9:0]  mem_addr;
  logic [1:0]  mem_be;
  logic [15:0] mem_wdata, mem_rdata, mem_rattr;
  logic        cpu_req = 1'b0, cpu_we = 1'b0;
  logic [10:0] cpu_addr = 11'h000, ca;
  logic [7:0]  cpu_wdata = 8'h00, dot_pattern = 8'h00, cpu_rdata, glyph_code, cr, cd;
  logic [3:0]  glyph_row;
  logic [6:0]  attr_out, fac_val, wide_val;
  int          n_errors = 0, check_count = 0, col, seed_ret;

  always #20 pclk = ~pclk;

  crtac_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .mem_addr, .mem_be, .mem_we, .mem_wdata, .mem_rdata, .mem_rattr, .cpu_req,
    .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .phi1, .phi2, .glyph_code,
    .glyph_row, .dot_pattern, .video, .hsync, .vsync, .blank, .attr_out, .cursor_hit);
  crtac_mem_model mem (.pclk, .mem_addr, .mem_be, .mem_we, .mem_wdata, .mem_rdata, .mem_rattr);

  // Space is the only dark glyph, so a lit cursor cell proves the inversion
  always @(posedge pclk) dot_pattern <= (glyph_code == 8'h20) ? 8'h00 : 8'h5a;

  ////////////////////////////////////////////////////////////////////////
  function automatic int exp_cycles(input int p);
    return int'((longint'(p) * 2 * CHAR_DIV * SYS_HZ) / VIDEO_HZ);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cpu_xfer(input logic we, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    cpu_req   <= 1'b1;
    cpu_we    <= we;
    cpu_addr  <= a;
    cpu_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 100);
    if (cpu_ack !== 1'b1) n_errors++;
    cr = cpu_rdata;
    cpu_req <= 1'b0;
  endtask

  task automatic write_cursor(input logic [10:0] v);
    apb(1'b1, REG_CUR_LO, {24'($urandom), v[7:0]});
    apb(1'b1, REG_CUR_HI, {29'($urandom), v[10:8]});
    apb(1'b0, REG_CUR_LO, 32'h0);
    chk("cursor_low", {24'h0, v[7:0]}, rd);
    apb(1'b0, REG_CUR_HI, 32'h0);
    chk("cursor_high", {29'h0, v[10:8]}, rd);
  endtask

  task automatic wait_blank(input logic lvl);
    int n;
    n = 0;
    while (blank !== lvl && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (blank !== lvl) n_errors++;
  endtask

  task automatic measure_line(input logic [6:0] mid, input int c, input bit hit);
    int first, hcyc, lit, hs;
    first = -1;
    hcyc = 0;
    lit = 0;
    hs = 0;
    wait_blank(1'b1);
    wait_blank(1'b0);
    // Long enough to take in the sync pulse, short of the next line start
    for (int t = 0; t < 1300; t++) begin
      @(posedge pclk);
      if (t == 30) chk("attr_line_start", 32'h0, {25'h0, attr_out});
      if (t == 30) chk("vsync_in_display", 32'h0, {31'h0, vsync});
      if (t == 30) chk("glyph_row_range", 32'h1, {31'h0, glyph_row <= SCAN_LAST});
      if (hsync === 1'b1) hs++;
      if (t == 800) chk("attr_mid_line", {25'h0, mid}, {25'h0, attr_out});
      if (cursor_hit === 1'b1) begin
        if (first < 0) first = t;
        hcyc++;
        if (video === 1'b1) lit++;
      end
    end
    chk_rng("cursor_cycles", hit ? 9 : 0, hit ? 30 : 0, hcyc);
    // Sync spans an even number of cells, so whole processor periods
    chk_rng("hsync_cycles", exp_cycles(int'(HS_END - HS_START + 7'h01) / 2) - 2,
            exp_cycles(int'(HS_END - HS_START + 7'h01) / 2) + 2, hs);
    if (hit) begin
      chk_rng("cursor_offset", c * 13 - 40, c * 14 + 40, first);
      chk_rng("cursor_lit", hcyc - 2, hcyc, lit);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int   n, rises, t0;
    logic last;
    seed_ret = $urandom(90368);
    fac_val  = 7'($urandom) | 7'h01;
    wide_val = 7'($urandom) | 7'h02;
    col      = 8 + int'($urandom % 28);
    for (int i = 0; i < 2048; i++) begin
      mem.ram[i]  = 8'h20;
      mem.attr[i] = 8'h00;
    end
    mem.ram[START_ADDR + 11'h028] = {1'b1, fac_val};
    for (int i = 20; i <= 70; i++) mem.attr[int'(START_ADDR) + i] = {1'b0, wide_val};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CUR_LO, 32'h0);
    chk("cur_lo_rst", 32'h0, rd);
    apb(1'b0, REG_CUR_HI, 32'h0);
    chk("cur_hi_rst", 32'h0, rd);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", {30'h0, CTRL_RST}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    write_cursor(START_ADDR + 11'(col));
    // Fifty processor clock periods, counted rise to rise
    rises = 0;
    n = 0;
    t0 = 0;
    last = 1'b1;
    while (rises < 51 && n < 5000) begin
      @(posedge pclk);
      n++;
      if (phi1 === 1'b1 && last === 1'b0) begin
        if (rises == 0) t0 = n;
        rises++;
      end
      last = phi1;
    end
    chk_rng("cpu_clk_periods", exp_cycles(50) - 3, exp_cycles(50) + 3, n - t0);
    // Below the screen area so the display is untouched; both lanes covered
    for (int i = 0; i < 4; i++) begin
      ca = (i == 0) ? 11'h000 : (i == 3) ? 11'h07f : 11'($urandom % 128);
      cd = 8'($urandom);
      cpu_xfer(1'b1, ca, cd);
      chk("ram_after_write", {24'h0, cd}, {24'h0, mem.ram[ca]});
      cpu_xfer(1'b0, ca, 8'h00);
      chk("cpu_read_back", {24'h0, cd}, {24'h0, cr});
    end
    measure_line(fac_val, col, 1'b1);
    measure_line(fac_val, col, 1'b1);
    write_cursor(START_ADDR + LINE_STEP + 11'(col));
    measure_line(fac_val, col, 1'b0);
    apb(1'b1, REG_CTRL, 32'h2);
    measure_line(wide_val, col, 1'b0);
    final_report();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    final_report();
  end
endmodule

bind crtac_top crtac_checker chk (.pclk, .presetn, .psel, .penable, .pready, .phi1, .phi2,
  .mem_we, .mem_be, .cpu_ack);
